//--- design/adc_port_regs.vh
`ifndef ADC_PORT_REGS_VH
`define ADC_PORT_REGS_VH

// register byte offsets
`define REG_CONTROL 5'h00
`define REG_STATUS 5'h04
`define REG_RESULT 5'h08

// control fields
`define CTRL_PORT_ENABLE 0
`define CTRL_RESET 1'b1

// status fields
`define STAT_MODE_LO 0
`define STAT_MODE_HI 1
`define STAT_SERIAL 2
`define STAT_MASTER 3
`define STAT_RATE_LOW 4
`define STAT_SHIFT_BUSY 5
`define STAT_READ_DURING 6

// axi responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// conversion modes, coded as {fast, lowPower}
`define MODE_NORMAL 2'b00
`define MODE_IMPULSE 2'b01
`define MODE_WARP 2'b10
`define MODE_WIDEBAND 2'b11

// timing
`define CLK_NS 20
`define SCLK_PERIOD0_NS 8
`define SCLK_PERIOD1_NS 16
`define SCLK_PERIOD2_NS 32
`define SCLK_PERIOD3_NS 64
// half period in cycles, rounded up, at least one
`define HALF_CYC(ns) ((((ns) / 2 + `CLK_NS - 1) / `CLK_NS) < 1 ? 1 : \
   (((ns) / 2 + `CLK_NS - 1) / `CLK_NS))
`define WARP_MAX_GAP_NS 1000000
`define WARP_MAX_GAP_CYC (`WARP_MAX_GAP_NS / `CLK_NS)

`endif

//--- design/sclk_divider.v
`timescale 1ns/1ps
module sclk_divider #(
   parameter WIDTH = 8
) (
   input wire clk,
   input wire rst,
   input wire run,
   input wire [WIDTH-1:0] halfCycles,
   output reg tick
);
   reg [WIDTH-1:0] count;

   // one-cycle enable every halfCycles clocks while running
   always @(posedge clk) begin
      if (rst || !run) begin
         count <= {WIDTH{1'b0}};
         tick <= 1'b0;
      end else if (count + 1'b1 >= halfCycles) begin
         count <= {WIDTH{1'b0}};
         tick <= 1'b1;
      end else begin
         count <= count + 1'b1;
         tick <= 1'b0;
      end
   end
endmodule // sclk_divider

//--- design/serial_shifter.v
`timescale 1ns/1ps
module serial_shifter #(
   parameter WIDTH = 16
) (
   input wire clk,
   input wire rst,
   input wire load,
   input wire [WIDTH-1:0] loadWord,
   input wire advance,
   output wire bitOut,
   output wire busy
);
   // bit count of one frame at the counter's own width
   localparam [4:0] FULL_COUNT = WIDTH;
   reg [WIDTH-1:0] shiftReg;
   reg [4:0] bitsLeft;

   // msb first; a load restarts any transfer in progress
   always @(posedge clk) begin
      if (rst) begin
         shiftReg <= {WIDTH{1'b0}};
         bitsLeft <= 5'h00;
      end else if (load) begin
         shiftReg <= loadWord;
         bitsLeft <= FULL_COUNT;
      end else if (advance && bitsLeft != 5'h00) begin
         shiftReg <= {shiftReg[WIDTH-2:0], 1'b0};
         bitsLeft <= bitsLeft - 5'h01;
      end
   end

   assign bitOut = shiftReg[WIDTH-1];
   assign busy = (bitsLeft != 5'h00);
endmodule // serial_shifter

//--- design/adc_output_port_mode_decode.v
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "adc_port_regs.vh"
module adc_output_port_mode_decode #(
   parameter ADDR_WIDTH = 5,
   parameter WARP_MAX_GAP = `WARP_MAX_GAP_CYC
) (
   input wire clk,
   input wire rst,
   input wire [ADDR_WIDTH-1:0] awaddr,
   input wire awvalid,
   output reg awready,
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   input wire wvalid,
   output reg wready,
   output reg [1:0] bresp,
   output reg bvalid,
   input wire bready,
   input wire [ADDR_WIDTH-1:0] araddr,
   input wire arvalid,
   output reg arready,
   output reg [31:0] rdata,
   output reg [1:0] rresp,
   output reg rvalid,
   input wire rready,
   input wire byteOrderSelect,
   input wire outputCodingSelect,
   input wire fastModeSelect,
   input wire lowPowerSelect,
   input wire serialParallelSelect,
   input wire csN,
   input wire [15:0] dataIn,
   output reg [15:0] dataOut,
   output reg [15:0] dataOe,
   input wire sclkIn,
   output reg sclkOut,
   output reg sclkOe,
   input wire convStart,
   input wire convDone,
   input wire [15:0] convResult,
   output reg [1:0] convMode
);
   localparam SERIAL_OUT_PIN = 8;
   // half periods at the divider's width, so nothing is narrowed at the mux
   localparam [7:0] HALF0 = `HALF_CYC(`SCLK_PERIOD0_NS);
   localparam [7:0] HALF1 = `HALF_CYC(`SCLK_PERIOD1_NS);
   localparam [7:0] HALF2 = `HALF_CYC(`SCLK_PERIOD2_NS);
   localparam [7:0] HALF3 = `HALF_CYC(`SCLK_PERIOD3_NS);

   reg portEnable;
   reg rateLow;
   reg [15:0] lastResult;
   reg [31:0] gapCount;
   reg sclkPrev;
   reg sclkInt;
   reg awHeld;
   reg wHeld;
   reg [ADDR_WIDTH-1:0] wAddr;
   reg [31:0] wData;
   reg [3:0] wStrb;

   wire serialSel;
   wire masterSel;
   wire readDuring;
   wire [1:0] divSel;
   wire [15:0] coded;
   wire [15:0] ordered;
   wire shiftBit;
   wire shiftBusy;
   wire sclkTick;
   wire shiftLoad;
   wire [15:0] shiftWord;
   wire shiftAdvance;
   wire writeGo;
   wire rateClear;
   reg [7:0] halfCycles;
   reg [31:0] readWord;
   reg [1:0] readResp;
   reg [15:0] next_dataOut;
   reg [15:0] next_dataOe;

   // strap decode; in serial mode pins 4, 7 and 3..2 turn into inputs
   assign serialSel = serialParallelSelect;
   assign masterSel = serialSel && !dataIn[4];
   assign readDuring = serialSel && dataIn[7];
   // divider only honoured in master read-after-convert, else fastest
   assign divSel = (masterSel && !readDuring) ? dataIn[3:2] : 2'b00;

   // coding then byte placement
   assign coded = {outputCodingSelect ? convResult[15] : ~convResult[15],
      convResult[14:0]};
   assign ordered = byteOrderSelect ? {lastResult[7:0], lastResult[15:8]} :
      lastResult;

   // minimum half periods of the internal serial clock per setting
   always @* begin
      case (divSel)
         2'b00: halfCycles = HALF0;
         2'b01: halfCycles = HALF1;
         2'b10: halfCycles = HALF2;
         2'b11: halfCycles = HALF3;
         default: halfCycles = HALF0;
      endcase
   end

   // read during convert in master mode sends the held previous word at conversion start
   assign shiftLoad = serialSel && (readDuring && masterSel ? convStart : convDone);
   assign shiftWord = (readDuring && masterSel) ? lastResult : coded;
   // advance on the falling edge so data is stable at the host's rising edge
   assign shiftAdvance = !csN && (masterSel ? (sclkTick && sclkInt) :
      (sclkPrev && !sclkIn));

   sclk_divider #(.WIDTH(8)) divider (
      .clk(clk),
      .rst(rst),
      .run(masterSel && shiftBusy && !csN),
      .halfCycles(halfCycles),
      .tick(sclkTick)
   );

   serial_shifter #(.WIDTH(16)) shifter (
      .clk(clk),
      .rst(rst),
      .load(shiftLoad),
      .loadWord(shiftWord),
      .advance(shiftAdvance),
      .bitOut(shiftBit),
      .busy(shiftBusy)
   );

   // result capture, mode register and serial clock generation
   always @(posedge clk) begin
      if (rst) begin
         lastResult <= 16'h0000;
         convMode <= `MODE_NORMAL;
         sclkInt <= 1'b0;
         sclkPrev <= 1'b0;
      end else begin
         convMode <= {fastModeSelect, lowPowerSelect};
         sclkPrev <= sclkIn;
         if (convDone) begin
            lastResult <= coded;
         end
         if (!masterSel || csN || !shiftBusy) begin
            sclkInt <= 1'b0;
         end else if (sclkTick) begin
            sclkInt <= ~sclkInt;
         end
      end
   end

   // conversion gap watch: only the fast modes, warp and wideband, lose accuracy when idle
   assign rateClear = writeGo && wAddr == `REG_STATUS && wStrb[0] &&
      wData[`STAT_RATE_LOW];
   always @(posedge clk) begin
      if (rst) begin
         gapCount <= 32'h00000000;
         rateLow <= 1'b0;
      end else begin
         if (convStart || !convMode[1]) begin
            gapCount <= 32'h00000000;
         end else if (gapCount < WARP_MAX_GAP) begin
            gapCount <= gapCount + 32'h00000001;
         end
         // set wins over the software clear
         if (convMode[1] && !convStart && gapCount >= WARP_MAX_GAP) begin
            rateLow <= 1'b1;
         end else if (rateClear) begin
            rateLow <= 1'b0;
         end
      end
   end

   // pin drive selection
   always @* begin
      next_dataOut = 16'h0000;
      next_dataOe = 16'h0000;
      if (portEnable && !serialSel) begin
         next_dataOut = ordered;
         next_dataOe = csN ? 16'h0000 : 16'hffff;
      end else if (portEnable) begin
         // only the serial output drives; straps and spare bits float
         next_dataOut[SERIAL_OUT_PIN] = shiftBit;
         next_dataOe[SERIAL_OUT_PIN] = !csN;
      end
   end

   // registered pins so every output comes from a flop
   always @(posedge clk) begin
      if (rst) begin
         dataOut <= 16'h0000;
         dataOe <= 16'h0000;
         sclkOut <= 1'b0;
         sclkOe <= 1'b0;
      end else begin
         dataOut <= next_dataOut;
         dataOe <= next_dataOe;
         sclkOut <= sclkInt;
         sclkOe <= portEnable && masterSel && !csN;
      end
   end

   // axi write side: address and data taken in either order
   assign writeGo = awHeld && wHeld && !bvalid;
   always @(posedge clk) begin
      if (rst) begin
         awready <= 1'b0;
         wready <= 1'b0;
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         wAddr <= {ADDR_WIDTH{1'b0}};
         wData <= 32'h00000000;
         wStrb <= 4'h0;
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
         portEnable <= `CTRL_RESET;
      end else begin
         if (awvalid && awready) begin
            awready <= 1'b0;
            awHeld <= 1'b1;
            wAddr <= awaddr;
         end else if (!awHeld && !bvalid) begin
            awready <= 1'b1;
         end
         if (wvalid && wready) begin
            wready <= 1'b0;
            wHeld <= 1'b1;
            wData <= wdata;
            wStrb <= wstrb;
         end else if (!wHeld && !bvalid) begin
            wready <= 1'b1;
         end
         if (writeGo) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            bvalid <= 1'b1;
            bresp <= `RESP_OKAY;
            if (wAddr == `REG_CONTROL) begin
               if (wStrb[0]) begin
                  portEnable <= wData[`CTRL_PORT_ENABLE];
               end
            end else if (wAddr != `REG_STATUS && wAddr != `REG_RESULT) begin
               bresp <= `RESP_SLVERR; // unmapped
            end
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // read mux
   always @* begin
      readWord = 32'h00000000;
      readResp = `RESP_OKAY;
      case (araddr)
         `REG_CONTROL: readWord[`CTRL_PORT_ENABLE] = portEnable;
         `REG_STATUS: begin
            readWord[`STAT_MODE_HI:`STAT_MODE_LO] = convMode;
            readWord[`STAT_SERIAL] = serialSel;
            readWord[`STAT_MASTER] = masterSel;
            readWord[`STAT_RATE_LOW] = rateLow;
            readWord[`STAT_SHIFT_BUSY] = shiftBusy;
            readWord[`STAT_READ_DURING] = readDuring;
         end
         `REG_RESULT: readWord[15:0] = lastResult;
         default: readResp = `RESP_SLVERR;
      endcase
   end

   // axi read side: one read at a time, answer the cycle after the address
   always @(posedge clk) begin
      if (rst) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= `RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= readWord;
         rresp <= readResp;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end else if (!rvalid) begin
         arready <= 1'b1;
      end
   end
endmodule // adc_output_port_mode_decode

//--- tb/pins_sva.sv
`timescale 1ns/1ps
module pins_sva (
   input wire logic clk,
   input wire logic rst,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic byteOrderSelect,
   input wire logic outputCodingSelect,
   input wire logic fastModeSelect,
   input wire logic lowPowerSelect,
   input wire logic serialParallelSelect,
   input wire logic csN,
   input wire logic [15:0] dataIn,
   input wire logic [15:0] dataOut,
   input wire logic [15:0] dataOe,
   input wire logic sclkOut,
   input wire logic sclkOe,
   input wire logic convDone,
   input wire logic [15:0] convResult,
   input wire logic [1:0] convMode
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // coding then byte placement, as the parallel bus shows it
   function automatic logic [15:0] onBus(input logic [15:0] r, input logic ob, input logic bo);
      logic [15:0] c;
      c = ob ? r : r ^ 16'h8000;
      return bo ? {c[7:0], c[15:8]} : c;
   endfunction
   sequence s_parDone;
      convDone && !csN && !serialParallelSelect;
   endsequence
   sequence s_parShown;
      ##2 dataOut == onBus($past(convResult, 2), $past(outputCodingSelect, 2), byteOrderSelect);
   endsequence
   property p_par_word;
      s_parDone |-> s_parShown;
   endproperty
   a_par_word: assert property (p_par_word) else $error("parallel word wrong");
   // stable straps only, so a register stage in the decode is allowed
   property p_mode;
      !$past(rst) && $stable({fastModeSelect, lowPowerSelect})
         |-> convMode == {fastModeSelect, lowPowerSelect};
   endproperty
   a_mode: assert property (p_mode) else $error("mode decode wrong");
   property p_ser_float;
      $past(serialParallelSelect) |-> (dataOe & 16'hfeff) == 16'h0000;
   endproperty
   a_ser_float: assert property (p_ser_float) else $error("serial pin driven");
   property p_no_sclk;
      $past(serialParallelSelect && dataIn[4]) && $past(serialParallelSelect && dataIn[4], 2)
         |-> !sclkOe;
   endproperty
   a_no_sclk: assert property (p_no_sclk) else $error("slave drives clock");
   property p_slow;
      $changed(sclkOut) && $past(serialParallelSelect && dataIn[4:2] == 3'b011 && !dataIn[7])
         |=> $stable(sclkOut);
   endproperty
   a_slow: assert property (p_slow) else $error("serial clock too fast");
   property p_write_ans;
      awvalid && awready && wvalid && wready |-> ##2 bvalid;
   endproperty
   a_write_ans: assert property (p_write_ans) else $error("no write response");
   property p_bhold;
      bvalid && !bready |=> bvalid;
   endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");
   property p_rhold;
      rvalid && !rready |=> rvalid;
   endproperty
   a_rhold: assert property (p_rhold) else $error("read response dropped");
endmodule // pins_sva

//--- tb/host_reader.sv
`timescale 1ns/1ps
module host_reader (
   input wire logic clk,
   input wire logic start,
   input wire logic master,
   input wire logic sdo,
   input wire logic sclkOut,
   output logic sclk,
   output logic [15:0] word,
   output logic done
);
   int n;
   int t;
   logic prevClk;
   initial begin
      sclk = 0;
      word = 0;
      done = 0;
      n = 16;
      t = 0;
      prevClk = 0;
   end
   // slave clock idles low between frames; slow halves leave the pin time to settle
   always @(posedge clk) begin
      prevClk <= sclkOut;
      if (start) begin
         n <= 0;
         t <= 0;
         done <= 0;
      end else if (n < 16) begin
         if (master) begin
            if (sclkOut && !prevClk) begin
               word <= {word[14:0], sdo};
               n <= n + 1;
            end
         end else if (t == 3) begin
            sclk <= ~sclk;
            t <= 0;
            if (!sclk) begin
               word <= {word[14:0], sdo};
               n <= n + 1;
            end
         end else t <= t + 1;
      end else begin
         done <= 1;
         sclk <= 0;
      end
   end
endmodule // host_reader

//--- tb/adc_output_port_mode_decode_bench.sv
`timescale 1ns/1ps
module adc_output_port_mode_decode_bench;
   logic clk, rst, awvalid, wvalid, bready, arvalid, rready, csN, convStart, convDone;
   logic byteOrderSelect, outputCodingSelect, fastModeSelect, lowPowerSelect;
   logic serialParallelSelect, hostStart;
   logic [4:0] awaddr, araddr;
   logic [31:0] wdata, rd;
   logic [3:0] wstrb;
   logic [1:0] rs;
   logic [15:0] strap, convResult, expWord;
   wire awready, wready, bvalid, arready, rvalid, sclkOut, sclkOe, sclkIn, hostSclk, hostDone;
   wire [1:0] bresp, rresp, convMode;
   wire [31:0] rdata;
   wire [15:0] dataIn, dataOut, dataOe, word;
   int err_count, checks_done, k;
   // pin levels resolve from whichever side drives them
   assign dataIn = (dataOe & dataOut) | (~dataOe & strap);
   assign sclkIn = sclkOe ? sclkOut : hostSclk;
   adc_output_port_mode_decode #(.WARP_MAX_GAP(20)) i_dut (.*);
   host_reader i_host (.clk(clk), .start(hostStart), .master(!strap[4]), .sdo(dataIn[8]),
      .sclkOut(sclkOut), .sclk(hostSclk), .word(word), .done(hostDone));
   initial begin
      clk = 0;
      forever #10 clk = ~clk;
   end
   task automatic finish_test;
      if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [15:0] coded(input logic [15:0] r, input logic ob);
      return ob ? r : r ^ 16'h8000;
   endfunction
   // one bus transfer; each channel drops its valid once taken
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] wd,
      output logic [31:0] d, output logic [1:0] r);
      logic pa, pw, pb;
      pa = 1;
      pw = w;
      pb = 1;
      d = 0;
      r = 0;
      if (w) begin
         awaddr <= a;
         wdata <= wd;
         awvalid <= 1;
         wvalid <= 1;
         bready <= 1;
      end else begin
         araddr <= a;
         arvalid <= 1;
         rready <= 1;
      end
      for (int i = 0; pb && i < 40; i++) begin
         @(posedge clk);
         if (pa && (w ? awready : arready)) begin
            pa = 0;
            awvalid <= 0;
            arvalid <= 0;
         end
         if (pw && wready) begin
            pw = 0;
            wvalid <= 0;
         end
         if (w ? bvalid : rvalid) begin
            pb = 0;
            bready <= 0;
            rready <= 0;
            d = rdata;
            r = w ? bresp : rresp;
         end
      end
      if (pb) begin
         err_count++;
         finish_test();
      end
      @(posedge clk);
   endtask
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, convStart, convDone, hostStart} = 0;
      {byteOrderSelect, outputCodingSelect, fastModeSelect, lowPowerSelect} = 0;
      {serialParallelSelect, csN} = 0;
      awaddr = 0;
      araddr = 0;
      wdata = 0;
      wstrb = 4'hf;
      strap = 0;
      convResult = 0;
      err_count = 0;
      checks_done = 0;
      rst = 1;
      void'($urandom(32'hfb84d7ff));
      repeat (2) @(posedge clk);
      rst <= 0;
      repeat (2) @(posedge clk);
      // register map: reset value, read-only place, unmapped places
      bus(0, 5'h00, 0, rd, rs);
      chk(rd[0], 1'b1);
      bus(0, 5'h0c, 0, rd, rs);
      chk(rs, 2'b10);
      chk(rd, 32'h0);
      bus(1, 5'h10, 32'h1, rd, rs);
      chk(rs, 2'b10);
      bus(1, 5'h08, 32'hffff, rd, rs);
      chk(rs, 2'b00);
      // parallel results, the sign boundary first, then random words, with random straps throughout
      for (int i = 0; i < 12; i++) begin
         {byteOrderSelect, outputCodingSelect, fastModeSelect, lowPowerSelect} <= 4'($urandom);
         convResult <= i == 0 ? 16'h8000 : i == 1 ? 16'h7fff : 16'($urandom);
         convStart <= 1;
         @(posedge clk);
         convStart <= 0;
         convDone <= 1;
         @(posedge clk);
         convDone <= 0;
         repeat (3) @(posedge clk);
         expWord = coded(convResult, outputCodingSelect);
         chk(dataOut, byteOrderSelect ? {expWord[7:0], expWord[15:8]} : expWord);
         chk(dataOe, 16'hffff);
         chk(convMode, {fastModeSelect, lowPowerSelect});
         bus(0, 5'h08, 0, rd, rs);
         chk(rd[15:0], expWord);
      end
      // warp left idle past the gap limit, then normal mode stays quiet
      {fastModeSelect, lowPowerSelect} <= 2'b10;
      repeat (30) @(posedge clk);
      bus(0, 5'h04, 0, rd, rs);
      chk(rd[4], 1'b1);
      {fastModeSelect, lowPowerSelect} <= 2'b00;
      bus(1, 5'h04, 32'h10, rd, rs);
      repeat (30) @(posedge clk);
      bus(0, 5'h04, 0, rd, rs);
      chk(rd[4], 1'b0);
      // serial: host-clocked slave, master read-after at the slowest divider, read-during
      serialParallelSelect <= 1;
      for (int m = 0; m < 3; m++) begin
         expWord = coded(convResult, outputCodingSelect); // word held from the last conversion
         strap <= (16'($urandom) & 16'hff63) |
            (m == 0 ? 16'h0010 : m == 1 ? 16'h000c : 16'h0080);
         convResult <= 16'($urandom);
         outputCodingSelect <= 1'($urandom);
         @(posedge clk);
         hostStart <= m != 0;
         convStart <= m == 2;
         convDone <= m != 2;
         @(posedge clk);
         convStart <= 0;
         convDone <= 0;
         hostStart <= 0;
         repeat (4) @(posedge clk);
         hostStart <= m == 0;
         @(posedge clk);
         hostStart <= 0;
         @(posedge clk);
         for (k = 0; k < 400 && hostDone !== 1'b1; k++) @(posedge clk);
         if (k == 400) begin
            err_count++;
            finish_test();
         end
         chk(word, m == 2 ? expWord : coded(convResult, outputCodingSelect));
         chk(dataOe, 16'h0100);
         chk(sclkOe, m != 0);
      end
      csN <= 1;
      repeat (3) @(posedge clk);
      chk(dataOe, 16'h0000);
      finish_test();
   end
endmodule // adc_output_port_mode_decode_bench
bind adc_output_port_mode_decode pins_sva i_sva (.*);
